//--- rcb_term_cfg.sv
// Terminal configuration word: register, bus inhibits, command and rx buffer
`include "rcb_reg_map.svh"
`default_nettype none
module rcb_term_cfg
    import rcb_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16,
    parameter int TMP_DEPTH = `RCB_TMP_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic shutdown_scope_select,
    input wire logic global_bus_a_tx_block,
    input wire logic global_bus_b_tx_block,
    input wire logic global_bus_a_tx_block_bit,
    input wire logic global_bus_b_tx_block_bit,
    input wire logic terminal_execution_enable,
    output logic bus_a_tx_inhibit,
    output logic bus_a_rx_inhibit,
    output logic bus_b_tx_inhibit,
    output logic bus_b_rx_inhibit,
    output logic [1:0] rtrt_timeout_sel,
    output logic [5:0] cfg_low_fields,
    input wire logic cmd_stb,
    input wire rcb_cmd_t cmd,
    input wire logic [4:0] own_addr,
    input wire logic cmd_illegal,
    output logic verdict_stb,
    output rcb_verdict_t verdict,
    input wire logic rx_word_stb,
    input wire logic [DATA_W-1:0] rx_word,
    input wire logic msg_end_stb,
    input wire logic msg_end_err,
    output logic mem_wr_stb,
    output logic [4:0] mem_wr_offset,
    output logic [DATA_W-1:0] mem_wr_data,
    output logic mem_wr_bcst_area,
    output logic copy_busy
);

    localparam int IDX_W = $clog2(TMP_DEPTH + 1);

    logic [DATA_W-1:0] cfg_q;
    rcb_cfg_t cfg;
    logic hit_cfg;

    // Pin synchronisers: first stage feeds only the second
    logic pin_a_s1_q;
    logic pin_a_s2_q;
    logic pin_b_s1_q;
    logic pin_b_s2_q;

    // Temporary receive buffer
    logic [DATA_W-1:0] tmp_mem_q [TMP_DEPTH];
    logic [IDX_W-1:0] wr_idx_q;
    logic [IDX_W-1:0] cp_idx_q;
    logic [IDX_W-1:0] cp_cnt_q;
    logic [4:0] direct_idx_q;
    rcb_tb_state_t tb_state_q;
    rcb_tb_state_t tb_state_d;
    logic msg_bcst_sep_q;
    logic tmp_on;

    assign hit_cfg = (reg_addr == ADDR_W'(`RCB_ADDR_TERM_CFG));

    assign cfg.rtrt_timeout = cfg_q[`RCB_BIT_TMO_HI:`RCB_BIT_TMO_LO];
    assign cfg.term_bus_a_block = cfg_q[`RCB_BIT_BUS_A];
    assign cfg.term_bus_b_block = cfg_q[`RCB_BIT_BUS_B];
    assign cfg.broadcast_invalid = cfg_q[`RCB_BIT_BCST_INV];
    assign cfg.undefined_modecode_invalid = cfg_q[`RCB_BIT_UMC_INV];
    assign cfg.separate_broadcast_storage = cfg_q[`RCB_BIT_SEP_BCST];
    assign cfg.simplified_modecode_handling = cfg_q[`RCB_BIT_SIMPLE_MC];
    assign cfg.temp_receive_buffer_enable = cfg_q[`RCB_BIT_TMP_BUF];
    assign cfg.low_fields = cfg_q[`RCB_BIT_LOW_HI:`RCB_BIT_LOW_LO];

    // Config word storage; the unused bit is never stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_q <= `RCB_CFG_RESET;
        end else if (reg_wr_stb && hit_cfg) begin
            cfg_q <= reg_wdata & `RCB_CFG_WR_MASK;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd_stb && hit_cfg) begin
            reg_rdata <= cfg_q & `RCB_CFG_WR_MASK;
        end else begin
            reg_rdata <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_a_s1_q <= 1'b0;
            pin_a_s2_q <= 1'b0;
            pin_b_s1_q <= 1'b0;
            pin_b_s2_q <= 1'b0;
        end else begin
            pin_a_s1_q <= global_bus_a_tx_block;
            pin_a_s2_q <= pin_a_s1_q;
            pin_b_s1_q <= global_bus_b_tx_block;
            pin_b_s2_q <= pin_b_s1_q;
        end
    end

    // Scope select high limits the per-terminal block to transmit only;
    // global blocks act on transmit regardless of the per-terminal bits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_a_tx_inhibit <= 1'b0;
            bus_a_rx_inhibit <= 1'b0;
            bus_b_tx_inhibit <= 1'b0;
            bus_b_rx_inhibit <= 1'b0;
        end else begin
            bus_a_tx_inhibit <= cfg.term_bus_a_block ||
                pin_a_s2_q || global_bus_a_tx_block_bit;
            bus_a_rx_inhibit <= cfg.term_bus_a_block &&
                !shutdown_scope_select;
            bus_b_tx_inhibit <= cfg.term_bus_b_block ||
                pin_b_s2_q || global_bus_b_tx_block_bit;
            bus_b_rx_inhibit <= cfg.term_bus_b_block &&
                !shutdown_scope_select;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rtrt_timeout_sel <= '0;
            cfg_low_fields <= '0;
        end else begin
            rtrt_timeout_sel <= cfg.rtrt_timeout;
            cfg_low_fields <= cfg.low_fields;
        end
    end

    rcb_cmd_qual u_cmd_qual (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cmd_stb(cmd_stb),
        .cmd(cmd),
        .own_addr(own_addr),
        .cmd_illegal(cmd_illegal),
        .cfg(cfg),
        .verdict_stb(verdict_stb),
        .verdict(verdict)
    );

    // Broadcast area choice is latched per message from the verdict
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            msg_bcst_sep_q <= 1'b0;
        end else if (verdict_stb) begin
            msg_bcst_sep_q <= verdict.bcst_store_sep;
        end
    end

    // Mode bit is read live: the host keeps it still while executing
    assign tmp_on = cfg.temp_receive_buffer_enable;

    always_comb begin
        tb_state_d = tb_state_q;
        case (tb_state_q)
            RCB_TB_IDLE: begin
                if (tmp_on && msg_end_stb && !msg_end_err &&
                    wr_idx_q != '0) begin
                    tb_state_d = RCB_TB_COPY;
                end
            end
            RCB_TB_COPY: begin
                if (cp_idx_q == cp_cnt_q - IDX_W'(1)) begin
                    tb_state_d = RCB_TB_IDLE;
                end
            end
            default: begin
                tb_state_d = RCB_TB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tb_state_q <= RCB_TB_IDLE;
        end else begin
            tb_state_q <= tb_state_d;
        end
    end

    // Collect index; words beyond the buffer depth are dropped
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_idx_q <= '0;
        end else if (msg_end_stb) begin
            wr_idx_q <= '0;
        end else if (tmp_on && rx_word_stb &&
                     tb_state_q == RCB_TB_IDLE &&
                     wr_idx_q < IDX_W'(TMP_DEPTH)) begin
            wr_idx_q <= wr_idx_q + IDX_W'(1);
        end
    end

    generate
        for (genvar i = 0; i < TMP_DEPTH; i++) begin : g_tmp
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    tmp_mem_q[i] <= '0;
                end else if (tmp_on && rx_word_stb &&
                             tb_state_q == RCB_TB_IDLE &&
                             wr_idx_q == IDX_W'(i)) begin
                    tmp_mem_q[i] <= rx_word;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cp_idx_q <= '0;
            cp_cnt_q <= '0;
        end else if (tb_state_q == RCB_TB_IDLE) begin
            cp_idx_q <= '0;
            cp_cnt_q <= wr_idx_q;
        end else begin
            cp_idx_q <= cp_idx_q + IDX_W'(1);
        end
    end

    // Pass-through offset for unbuffered mode restarts per message
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            direct_idx_q <= '0;
        end else if (msg_end_stb) begin
            direct_idx_q <= '0;
        end else if (!tmp_on && rx_word_stb) begin
            direct_idx_q <= direct_idx_q + 5'h01;
        end
    end

    // Without the buffer a failed message can leave partial data behind;
    // that is the cost of the lower latency
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_wr_stb <= 1'b0;
            mem_wr_offset <= '0;
            mem_wr_data <= '0;
        end else if (tb_state_q == RCB_TB_COPY) begin
            mem_wr_stb <= 1'b1;
            mem_wr_offset <= cp_idx_q[4:0];
            mem_wr_data <= tmp_mem_q[cp_idx_q[4:0]];
        end else if (!tmp_on && rx_word_stb) begin
            mem_wr_stb <= 1'b1;
            mem_wr_offset <= direct_idx_q;
            mem_wr_data <= rx_word;
        end else begin
            mem_wr_stb <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_wr_bcst_area <= 1'b0;
        end else begin
            mem_wr_bcst_area <= msg_bcst_sep_q;
        end
    end

    assign copy_busy = (tb_state_q == RCB_TB_COPY);

endmodule
`default_nettype wire

//--- rcb_reg_map.svh
// Register offsets, field positions and constants of the terminal config word
//
// Contract
// - Bit 13 set inhibits bus A per scope.
// - Bit 13 clear leaves only global bus A inhibit.
// - Bit 12 set inhibits bus B per scope.
// - Bit 12 clear leaves only global bus B inhibit.
// - Bit 11 high makes address 31 commands invalid.
// - Bit 11 low accepts address 31 as broadcast.
// - Bit 10 unused, always reads zero.
// - Bit 9 covers MC0-15 receive, MC16,18,19 transmit.
// - Bit 9 low: undefined codes valid, table decides.
// - Bit 9 high: listed undefined codes are invalid.
// - Bit 8 high stores broadcast data separately.
// - Bit 8 low shares broadcast and normal buffer.
// - Bit 7 selects simplified mode command handling.
// - Bit 6 buffers 32 words, copies on success.
// - Bits 13 to 6 clear on master reset.
// - Config word sits at 0x0017; bits 15-14 time-out.
`ifndef RCB_REG_MAP_SVH
`define RCB_REG_MAP_SVH

`define RCB_ADDR_TERM_CFG 8'h17
`define RCB_CFG_RESET 16'h0000
`define RCB_CFG_WR_MASK 16'hFBFF
`define RCB_BIT_TMO_HI 15
`define RCB_BIT_TMO_LO 14
`define RCB_BIT_BUS_A 13
`define RCB_BIT_BUS_B 12
`define RCB_BIT_BCST_INV 11
`define RCB_BIT_UNUSED 10
`define RCB_BIT_UMC_INV 9
`define RCB_BIT_SEP_BCST 8
`define RCB_BIT_SIMPLE_MC 7
`define RCB_BIT_TMP_BUF 6
`define RCB_BIT_LOW_HI 5
`define RCB_BIT_LOW_LO 0
`define RCB_BCST_ADDR 5'h1F
`define RCB_MODE_SA_LO 5'h00
`define RCB_MODE_SA_HI 5'h1F
`define RCB_MC_RX_UNDEF_MAX 5'h0F
`define RCB_MC_TX_UNDEF_A 5'h10
`define RCB_MC_TX_UNDEF_B 5'h12
`define RCB_MC_TX_UNDEF_C 5'h13
`define RCB_TMP_DEPTH 32

`endif

//--- rcb_pkg.sv
// Types shared by the terminal configuration block
`default_nettype none
package rcb_pkg;

    typedef struct packed {
        logic [1:0] rtrt_timeout;
        logic term_bus_a_block;
        logic term_bus_b_block;
        logic broadcast_invalid;
        logic undefined_modecode_invalid;
        logic separate_broadcast_storage;
        logic simplified_modecode_handling;
        logic temp_receive_buffer_enable;
        logic [5:0] low_fields;
    } rcb_cfg_t;

    typedef struct packed {
        logic [4:0] rt_addr;
        logic tr;
        logic [4:0] subaddr;
        logic [4:0] count;
    } rcb_cmd_t;

    typedef struct packed {
        logic accept;
        logic broadcast;
        logic mode_cmd;
        logic simplified;
        logic status_update;
        logic msg_error_set;
        logic status_only;
        logic bcst_store_sep;
    } rcb_verdict_t;

    typedef enum logic [1:0] {
        RCB_TB_IDLE = 2'b01,
        RCB_TB_COPY = 2'b10
    } rcb_tb_state_t;

endpackage
`default_nettype wire

//--- rcb_cmd_qual.sv
// Command qualifier: applies config word settings to each decoded command
`include "rcb_reg_map.svh"
`default_nettype none
module rcb_cmd_qual
    import rcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_stb,
    input wire rcb_cmd_t cmd,
    input wire logic [4:0] own_addr,
    input wire logic cmd_illegal,
    input wire rcb_cfg_t cfg,
    output logic verdict_stb,
    output rcb_verdict_t verdict
);

    logic is_bcst;
    logic addr_hit;
    logic is_mode;
    logic undef_mc;
    logic ok;

    assign is_bcst = (cmd.rt_addr == `RCB_BCST_ADDR);
    assign addr_hit = (cmd.rt_addr == own_addr) ||
                      (is_bcst && !cfg.broadcast_invalid);
    assign is_mode = (cmd.subaddr == `RCB_MODE_SA_LO) ||
                     (cmd.subaddr == `RCB_MODE_SA_HI);
    // Only the listed codes are affected; others stay table-driven
    assign undef_mc = is_mode &&
        ((!cmd.tr && cmd.count <= `RCB_MC_RX_UNDEF_MAX) ||
         (cmd.tr && (cmd.count == `RCB_MC_TX_UNDEF_A ||
                     cmd.count == `RCB_MC_TX_UNDEF_B ||
                     cmd.count == `RCB_MC_TX_UNDEF_C)));
    assign ok = addr_hit &&
                !(undef_mc && cfg.undefined_modecode_invalid);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            verdict_stb <= 1'b0;
        end else begin
            verdict_stb <= cmd_stb;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            verdict <= '0;
        end else if (cmd_stb) begin
            verdict.accept <= ok;
            verdict.broadcast <= ok && is_bcst;
            verdict.mode_cmd <= ok && is_mode;
            verdict.simplified <= ok && is_mode &&
                                  cfg.simplified_modecode_handling;
            // Invalid commands leave last-status untouched
            verdict.status_update <= ok;
            verdict.msg_error_set <= ok && cmd_illegal;
            verdict.status_only <= ok && cmd_illegal && !is_bcst;
            verdict.bcst_store_sep <= ok && is_bcst &&
                                      cfg.separate_broadcast_storage;
        end
    end

endmodule
`default_nettype wire

//--- rcb_term_cfg_asserts.sv
// Port-level assertions for the terminal configuration block
`include "rcb_reg_map.svh"
`default_nettype none
module rcb_term_cfg_asserts
    import rcb_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic shutdown_scope_select,
    input wire logic global_bus_a_tx_block,
    input wire logic global_bus_a_tx_block_bit,
    input wire logic global_bus_b_tx_block,
    input wire logic global_bus_b_tx_block_bit,
    input wire logic bus_a_tx_inhibit,
    input wire logic bus_a_rx_inhibit,
    input wire logic bus_b_tx_inhibit,
    input wire logic bus_b_rx_inhibit,
    input wire logic [1:0] rtrt_timeout_sel,
    input wire logic [5:0] cfg_low_fields,
    input wire logic copy_busy,
    input wire logic cmd_stb,
    input wire rcb_cmd_t cmd,
    input wire logic verdict_stb,
    input wire rcb_verdict_t verdict,
    input wire logic rx_word_stb,
    input wire logic [DATA_W-1:0] rx_word,
    input wire logic mem_wr_stb,
    input wire logic [DATA_W-1:0] mem_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cfg_q;
    logic hit;
    logic bcst;
    logic undef;
    assign hit = reg_addr == `RCB_ADDR_TERM_CFG;
    assign bcst = cmd.rt_addr == `RCB_BCST_ADDR;
    // Only the listed codes on the two mode subaddresses count
    assign undef = (cmd.subaddr == 5'h00 || cmd.subaddr == 5'h1F) && (cmd.tr
        ? (cmd.count == 5'h10 || cmd.count == 5'h12 || cmd.count == 5'h13)
        : cmd.count <= 5'h0F);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_q <= 16'h0000;
        end else if (reg_wr_stb && hit) begin
            cfg_q <= reg_wdata[15:0] & `RCB_CFG_WR_MASK;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_read_value: assert property (
        reg_rd_stb && hit |=> reg_rdata == $past(cfg_q))
        else $error("config read differs from last write");
    chk_rd_unmapped: assert property (
        reg_rd_stb && !hit |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_bus_a_rx: assert property (
        bus_a_rx_inhibit == ($past(cfg_q[13]) &&
        !$past(shutdown_scope_select)))
        else $error("bus a receive inhibit wrong");
    chk_bus_b_rx: assert property (
        bus_b_rx_inhibit == ($past(cfg_q[12]) &&
        !$past(shutdown_scope_select)))
        else $error("bus b receive inhibit wrong");
    chk_a_tx_clear: assert property (
        !global_bus_a_tx_block [*4] ##0
        (!cfg_q[13] && !global_bus_a_tx_block_bit) |=> !bus_a_tx_inhibit)
        else $error("bus a transmit inhibited without cause");
    chk_bcst_invalid: assert property (
        cmd_stb && bcst && cfg_q[11] |=> verdict_stb && !verdict.accept
        && !verdict.status_update)
        else $error("broadcast accepted while invalid");
    chk_bcst_valid: assert property (
        cmd_stb && bcst && !cfg_q[11] && !(undef && cfg_q[9])
        |=> verdict.accept && verdict.broadcast)
        else $error("valid broadcast refused");
    chk_undef_mode: assert property (
        cmd_stb && undef && cfg_q[9] |=> !verdict.accept)
        else $error("undefined mode code accepted");
    chk_simple_mode: assert property (
        verdict_stb |-> verdict.simplified
        == (verdict.mode_cmd && $past(cfg_q[7])))
        else $error("simplified flag wrong");
    chk_direct_write: assert property (
        rx_word_stb && !cfg_q[6] |=> mem_wr_stb
        && mem_wr_data == $past(rx_word))
        else $error("direct receive write missing");
    chk_b_tx_clear: assert property (
        !global_bus_b_tx_block [*4] ##0
        (!cfg_q[12] && !global_bus_b_tx_block_bit) |=> !bus_b_tx_inhibit)
        else $error("bus b transmit inhibited without cause");
    chk_a_tx_set: assert property (
        cfg_q[13] |=> bus_a_tx_inhibit)
        else $error("bus a transmit not inhibited");
    chk_b_tx_set: assert property (
        cfg_q[12] |=> bus_b_tx_inhibit)
        else $error("bus b transmit not inhibited");
    chk_outer_fields: assert property (
        rtrt_timeout_sel == $past(cfg_q[15:14])
        && cfg_low_fields == $past(cfg_q[5:0]))
        else $error("time-out or low fields differ from config");
    chk_copy_busy: assert property (
        mem_wr_stb && cfg_q[6] |-> $past(copy_busy))
        else $error("buffered write outside copy");
    cover property (cmd_stb && bcst ##1 verdict.broadcast);
    cover property (cmd_stb && undef && cfg_q[9]);
    cover property (rx_word_stb && cfg_q[6] ##[1:40] mem_wr_stb);
endmodule
bind rcb_term_cfg rcb_term_cfg_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    chk_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr_stb,
    .reg_rd_stb, .reg_rdata, .shutdown_scope_select, .global_bus_a_tx_block,
    .global_bus_a_tx_block_bit, .global_bus_b_tx_block,
    .global_bus_b_tx_block_bit, .bus_a_tx_inhibit, .bus_a_rx_inhibit,
    .bus_b_tx_inhibit, .bus_b_rx_inhibit, .rtrt_timeout_sel,
    .cfg_low_fields, .copy_busy, .cmd_stb, .cmd, .verdict_stb, .verdict,
    .rx_word_stb, .rx_word, .mem_wr_stb, .mem_wr_data);
`default_nettype wire

//--- rcb_host_model.sv
// Host processor model driving the register port
`default_nettype none
module rcb_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr_stb,
    output logic reg_rd_stb,
    output logic terminal_execution_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        terminal_execution_enable = 1'b1;
    end
    // Execution is dropped around every write so bit 6 never moves live
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        terminal_execution_enable <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_stb <= 1'b1;
        @(posedge clk_sys);
        reg_wr_stb <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        terminal_execution_enable <= 1'b1;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_stb <= 1'b1;
        @(posedge clk_sys);
        reg_rd_stb <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule
`default_nettype wire

//--- rcb_term_cfg_tb_top.sv
// Self-checking bench for the terminal configuration block
`include "rcb_reg_map.svh"
`default_nettype none
module rcb_term_cfg_tb_top import rcb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, sys_rst = 1, reg_wr_stb, reg_rd_stb;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rx_word = 0, mem_wr_data, cfg_m = 0;
    logic shutdown_scope_select = 0, global_bus_a_tx_block = 0;
    logic global_bus_b_tx_block = 0, global_bus_a_tx_block_bit = 0;
    logic global_bus_b_tx_block_bit = 0, terminal_execution_enable;
    logic bus_a_tx_inhibit, bus_a_rx_inhibit, bus_b_tx_inhibit;
    logic bus_b_rx_inhibit, verdict_stb, mem_wr_stb, mem_wr_bcst_area;
    logic [1:0] rtrt_timeout_sel;
    logic [5:0] cfg_low_fields;
    logic [4:0] own_addr = 5'h05, mem_wr_offset;
    logic cmd_stb = 0, cmd_illegal = 0, rx_word_stb = 0, msg_end_stb = 0;
    logic msg_end_err = 0, copy_busy, rd_seen = 0, last_sep = 0;
    logic [31:0] r;
    rcb_cmd_t cmd = '0, cmd_n;
    rcb_verdict_t verdict;
    logic [15:0] rd_q[$];
    rcb_verdict_t vd_q[$];
    logic [21:0] mw_q[$];
    int mismatches = 0, check_count = 0, cycles = 0;
    rcb_term_cfg dut_u (.*);
    rcb_host_model host_u (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic conclude();
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic report(string what, logic [21:0] e, logic [21:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_rd(logic [15:0] e, logic [15:0] g);
        report("reg_rdata", {6'h00, e}, {6'h00, g});
    endtask
    task automatic cmp_vd(rcb_verdict_t e, rcb_verdict_t g);
        report("verdict", {14'h0000, e}, {14'h0000, g});
    endtask
    task automatic cmp_mw(logic [21:0] e, logic [21:0] g);
        report("mem_wr", e, g);
    endtask
    // Results are paired with notes strictly in issue order
    always @(posedge clk_sys) begin
        rd_seen <= reg_rd_stb;
        if (rd_seen) cmp_rd(rd_q.pop_front(), reg_rdata);
        if (verdict_stb) cmp_vd(vd_q.pop_front(), verdict);
        if (mem_wr_stb) begin
            cmp_mw(mw_q.pop_front(),
                {mem_wr_bcst_area, mem_wr_offset, mem_wr_data});
        end
        if (!sys_rst) begin
            r = $urandom;
            shutdown_scope_select <= r[0];
            global_bus_a_tx_block <= &r[2:1];
            global_bus_b_tx_block <= &r[4:3];
            global_bus_a_tx_block_bit <= &r[6:5];
            global_bus_b_tx_block_bit <= r[7];
        end
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic wr(logic [7:0] a, logic [15:0] d);
        host_u.wr_reg(a, d);
        if (a == `RCB_ADDR_TERM_CFG) cfg_m = d & `RCB_CFG_WR_MASK;
    endtask
    task automatic rd(logic [7:0] a);
        rd_q.push_back(a == `RCB_ADDR_TERM_CFG ? cfg_m : 16'h0000);
        host_u.rd_reg(a);
    endtask
    function automatic rcb_verdict_t exp_vd(rcb_cmd_t c, logic ill);
        logic b, u, a, m;
        rcb_verdict_t v;
        b = c.rt_addr == 5'h1F;
        m = c.subaddr == 5'h00 || c.subaddr == 5'h1F;
        u = m && (c.tr ? (c.count == 5'h10 || c.count == 5'h12
            || c.count == 5'h13) : c.count <= 5'h0F);
        a = (c.rt_addr == own_addr || (b && !cfg_m[11]))
            && !(u && cfg_m[9]);
        v.accept = a;
        v.broadcast = a && b;
        v.mode_cmd = a && m;
        v.simplified = a && m && cfg_m[7];
        v.status_update = a;
        v.msg_error_set = a && ill;
        v.status_only = a && ill && !b;
        v.bcst_store_sep = a && b && cfg_m[8];
        return v;
    endfunction
    task automatic send_cmd(rcb_cmd_t c, logic ill);
        vd_q.push_back(exp_vd(c, ill));
        last_sep = vd_q[$].bcst_store_sep;
        @(posedge clk_sys);
        cmd <= c;
        cmd_illegal <= ill;
        cmd_stb <= 1'b1;
    endtask
    task automatic message(int n, logic err);
        logic [15:0] w;
        for (int i = 0; i < n; i++) begin
            w = 16'($urandom);
            if (!cfg_m[6] || (!err && i < 32)) begin
                mw_q.push_back({last_sep, i[4:0], w});
            end
            @(posedge clk_sys);
            rx_word <= w;
            rx_word_stb <= 1'b1;
        end
        @(posedge clk_sys);
        rx_word_stb <= 1'b0;
        msg_end_stb <= 1'b1;
        msg_end_err <= err;
        @(posedge clk_sys);
        msg_end_stb <= 1'b0;
        repeat (40) @(posedge clk_sys);
    endtask
    initial begin
        void'($urandom(32'h8EFF87A0));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h17);
        rd(8'h16);
        wr(8'h17, 16'hFFFF);
        rd(8'h17);
        for (int k = 0; k < 24; k++) begin
            wr(k[0] ? 8'h17 : 8'h18, 16'($urandom));
            rd(8'h17);
        end
        for (int k = 0; k < 16; k++) begin
            wr(8'h17, {4'h0, k[3], 1'b0, k[2:0], 7'h00});
            for (int j = 0; j < 12; j++) begin
                r = $urandom;
                cmd_n = r[15:0];
                if (r[17:16] == 2'b00) cmd_n.rt_addr = own_addr;
                if (r[17:16] == 2'b01) cmd_n.rt_addr = 5'h1F;
                if (r[19:18] == 2'b00) cmd_n.subaddr = 5'h00;
                if (r[19:18] == 2'b01) cmd_n.subaddr = 5'h1F;
                send_cmd(cmd_n, r[20]);
            end
            @(posedge clk_sys);
            cmd_stb <= 1'b0;
        end
        wr(8'h17, 16'h0100);
        send_cmd({5'h1F, 1'b0, 5'h01, 5'h02}, 1'b0);
        @(posedge clk_sys);
        cmd_stb <= 1'b0;
        repeat (4) @(posedge clk_sys);
        message(5, 1'b0);
        message(3, 1'b1);
        wr(8'h17, 16'h0140);
        message(2, 1'b0);
        message(34, 1'b0);
        message(4, 1'b1);
        wr(8'h17, 16'h3000);
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cfg_m = 16'h0000;
        rd(8'h17);
        repeat (4) @(posedge clk_sys);
        report("pending", 22'h0,
            22'(rd_q.size() + vd_q.size() + mw_q.size()));
        conclude();
    end
endmodule
`default_nettype wire
